// File: verilog/dpllr_pkg.sv
//----------------------------------------------------------------
// Notes on behaviour
//----------------------------------------------------------------
// Notes on behaviour
// RULE_01 - Each input falling edge samples loop output; inverted sample high when locked.
// RULE_02 - Lock shown only after a retriggerable timeout longer than four input periods.
// RULE_03 - With the edge detector the lock indicator is unreliable near centre.
// RULE_04 - With the edge detector the inverted sample is the decoded FSK bit.
// RULE_05 - Each input falling edge captures the whole feedback counter.
// RULE_06 - Reference feedback counter divides by 16, giving a 4-bit phase value.
// RULE_07 - Reported code is the bitwise inverse of the captured value.
// RULE_08 - Edge detector phase error is the absolute difference offset by half cycle.
// RULE_09 - Signed error is the inverted code with one subtracted at its MSB.
// RULE_10 - Error is accurate to one LSB, one N-th of a cycle.
// RULE_11 - Phase readout is meant for the edge detector mode.
// RULE_12 - Phase demodulation captures the counter on an external synchronous strobe.
// RULE_13 - Hold range extension divides both detector inputs by the same modulus L; the code divides only the fin falling edges, out on fin_div.
// RULE_14 - Timeout is a system clock counter reloaded on each trigger.
// RULE_15 - Input is synchronised and falling edges detected before use as strobes.
package dpllr_pkg;
   localparam int unsigned CNT_W = 4;
   localparam int unsigned CLK_HZ = 40000000;
   // Slowest supported input frequency
   localparam int unsigned FIN_MIN_HZ = 100000;
   localparam int unsigned TIMEOUT_PERIODS = 5;
   localparam int unsigned TIMEOUT_CYC = (CLK_HZ / FIN_MIN_HZ) * TIMEOUT_PERIODS;
   localparam int unsigned TMO_W = 24;
   localparam logic [CNT_W-1:0] CODE_RST = 4'h0;
   localparam int unsigned DIV_L_W = 8;
   localparam logic [DIV_L_W-1:0] DIV_L_RST = 8'h01;
   typedef enum logic [1:0] {
      DPLLR_SRC_EDGE = 2'b00,
      DPLLR_SRC_STROBE = 2'b01
   } dpllr_src_t;
endpackage

// File: verilog/dpllr_div_if.sv
`timescale 1ns/1ps
interface dpllr_div_if;
   import dpllr_pkg::*;
   logic tick;
   logic pulse;
   logic [DIV_L_W-1:0] modulus;
   modport master (output tick, output modulus, input pulse);
   modport slave (input tick, input modulus, output pulse);
endinterface

// File: verilog/dpllr_divider.sv
`timescale 1ns/1ps
module dpllr_divider
   import dpllr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   dpllr_div_if.slave div
);
   logic [DIV_L_W-1:0] cnt_q, cnt_d;
   logic pulse_q, pulse_d;

   always_comb begin
      cnt_d = cnt_q;
      pulse_d = 1'b0;
      if (div.tick) begin
         if (cnt_q + 8'h01 >= div.modulus) begin
            cnt_d = '0;
            pulse_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= '0;
         pulse_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         pulse_q <= pulse_d;
      end
   end

   assign div.pulse = pulse_q;
endmodule

// File: verilog/dpllr_top.sv
`timescale 1ns/1ps
module dpllr_top
   import dpllr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic fin,
   input wire logic [CNT_W-1:0] fb_count,
   input wire logic edge_mode,
   input wire logic strobe_mode,
   input wire logic ext_strobe,
   input wire logic [DIV_L_W-1:0] hold_modulus,
   output logic locked,
   output logic lock_valid,
   output logic fsk_bit,
   output logic [CNT_W-1:0] phase_code,
   output logic signed [CNT_W-1:0] phase_error,
   output logic code_valid,
   output logic fin_div
);
   //--------------------------------------------------------------
   // Input synchronisers
   //--------------------------------------------------------------
   logic [2:0] fin_s_q, fin_s_d;
   logic [CNT_W-1:0] fbc1_q, fbc2_q, fbc_d1, fbc_d2;
   logic [1:0] stb_s_q, stb_s_d;
   logic stb_prev_q, stb_prev_d;
   logic fall;
   logic cap;

   always_comb begin
      fin_s_d = {fin_s_q[1:0], fin}; // RULE_15
      fbc_d1 = fb_count;
      fbc_d2 = fbc1_q;
      stb_s_d = {stb_s_q[0], ext_strobe};
      stb_prev_d = stb_s_q[1];
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fin_s_q <= 3'h0;
         fbc1_q <= CODE_RST;
         fbc2_q <= CODE_RST;
         stb_s_q <= 2'h0;
         stb_prev_q <= 1'b0;
      end else begin
         fin_s_q <= fin_s_d;
         fbc1_q <= fbc_d1;
         fbc2_q <= fbc_d2;
         stb_s_q <= stb_s_d;
         stb_prev_q <= stb_prev_d;
      end
   end

   assign fall = fin_s_q[2] & ~fin_s_q[1]; // RULE_15
   // Strobe mode captures on rising edge of the external strobe
   assign cap = strobe_mode ? (stb_s_q[1] & ~stb_prev_q) : fall; // RULE_12

   //--------------------------------------------------------------
   // Hold range divider on the input edge stream
   //--------------------------------------------------------------
   dpllr_div_if div_i ();
   assign div_i.tick = fall;
   assign div_i.modulus = (hold_modulus == 8'h00) ? DIV_L_RST : hold_modulus; // RULE_13

   dpllr_divider u_div (
      .clk(clk),
      .reset_n(reset_n),
      .div(div_i)
   );

   logic fin_div_q, fin_div_d;
   always_comb begin
      fin_div_d = fin_div_q ^ div_i.pulse; // RULE_13
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fin_div_q <= 1'b0;
      end else begin
         fin_div_q <= fin_div_d;
      end
   end
   assign fin_div = fin_div_q;

   //--------------------------------------------------------------
   // Sample and capture
   //--------------------------------------------------------------
   logic samp_n_q, samp_n_d;
   logic [CNT_W-1:0] cap_q, cap_d;
   logic cv_q, cv_d;

   always_comb begin
      samp_n_d = samp_n_q;
      cap_d = cap_q;
      cv_d = 1'b0;
      if (fall) begin
         samp_n_d = ~fbc2_q[CNT_W-1]; // RULE_01
      end
      if (cap) begin
         cap_d = fbc2_q; // RULE_05 RULE_06
         cv_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         samp_n_q <= 1'b1;
         cap_q <= CODE_RST;
         cv_q <= 1'b0;
      end else begin
         samp_n_q <= samp_n_d;
         cap_q <= cap_d;
         cv_q <= cv_d;
      end
   end

   //--------------------------------------------------------------
   // Lock timeout
   //--------------------------------------------------------------
   logic [TMO_W-1:0] tmo_q, tmo_d;
   logic samp_prev_q, samp_prev_d;

   always_comb begin
      tmo_d = tmo_q;
      samp_prev_d = samp_n_q;
      if (samp_prev_q & ~samp_n_q) begin
         tmo_d = TMO_W'(TIMEOUT_CYC); // RULE_02 RULE_14
      end else if (tmo_q != '0) begin
         tmo_d = tmo_q - 1'b1; // RULE_14
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tmo_q <= TMO_W'(TIMEOUT_CYC);
         samp_prev_q <= 1'b1;
      end else begin
         tmo_q <= tmo_d;
         samp_prev_q <= samp_prev_d;
      end
   end

   assign locked = (tmo_q == '0); // RULE_02
   assign lock_valid = ~edge_mode; // RULE_03
   assign fsk_bit = samp_n_q; // RULE_04

   //--------------------------------------------------------------
   // Code readout
   //--------------------------------------------------------------
   function automatic logic signed [CNT_W-1:0] to_error(input logic [CNT_W-1:0] c);
      to_error = signed'({~c[CNT_W-1], c[CNT_W-2:0]}); // RULE_09 RULE_08
   endfunction

   always_comb begin
      phase_code = ~cap_q; // RULE_07 RULE_11
      // Captured count less half a cycle, so code 0000 reads +7
      phase_error = to_error(cap_q); // RULE_10
   end
   assign code_valid = cv_q;
endmodule

// File: bench/dpllr_props.sv
`timescale 1ns/1ps
module dpllr_props
   import dpllr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic fin,
   input wire logic edge_mode,
   input wire logic strobe_mode,
   input wire logic ext_strobe,
   input wire logic locked,
   input wire logic lock_valid,
   input wire logic fsk_bit,
   input wire logic [CNT_W-1:0] phase_code,
   input wire logic signed [CNT_W-1:0] phase_error,
   input wire logic code_valid
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_lock_valid_mode: assert property (lock_valid == !edge_mode)
      else $error("lock_valid wrong");
   a_error_from_code: assert property (phase_error == 4'h7 - phase_code)
      else $error("phase_error wrong");
   a_code_moves_valid: assert property ($changed(phase_code) |-> code_valid)
      else $error("code moved alone");
   a_valid_single: assert property (code_valid |=> !code_valid)
      else $error("code_valid long");
   a_fin_capture: assert property ($fell(fin) && !strobe_mode |-> ##[2:5] code_valid)
      else $error("no capture on fin");
   a_strobe_capture: assert property ($rose(ext_strobe) && strobe_mode |-> ##[2:5] code_valid)
      else $error("no strobe capture");
   a_fsk_matches: assert property (code_valid && !strobe_mode |-> fsk_bit == phase_code[3])
      else $error("fsk_bit wrong");
   a_lock_retrigger: assert property ($fell(fsk_bit) |=> !locked [*8])
      else $error("locked after trigger");
endmodule
bind dpllr_top dpllr_props i_dpllr_props (.*);

// File: bench/dpllr_fb_model.sv
`timescale 1ns/1ps
module dpllr_fb_model
   import dpllr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   output logic [CNT_W-1:0] fb_count
);
   logic [3:0] pre_q;
   // Divide-by-16 feedback counter, one step per 16 clocks
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pre_q <= 4'h0;
         fb_count <= 4'h0;
      end else begin
         pre_q <= pre_q + 4'h1;
         fb_count <= fb_count + {3'h0, pre_q == 4'hf};
      end
   end
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import dpllr_pkg::*;
   logic clk = 0, reset_n = 0, fin = 1, edge_mode = 1, strobe_mode = 0, ext_strobe = 0;
   logic [DIV_L_W-1:0] hold_modulus = 8'h03;
   logic [CNT_W-1:0] fb_count, phase_code;
   logic signed [CNT_W-1:0] phase_error;
   logic locked, lock_valid, fsk_bit, code_valid, fin_div;
   int errors = 0, check_count = 0;
   always #12.5 clk = ~clk;
   dpllr_fb_model i_dpllr_fb_model (.*);
   dpllr_top i_dpllr_top (.*);
   task automatic tick(int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic compare(string name, logic [3:0] exp, logic [3:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic compare_cycles(string name, int exp, int got);
      check_count++;
      if (got != exp) begin
         errors++;
         $display("mismatch %s expected %0d seen %0d", name, exp, got);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Capture while the counter holds v, by fin fall or by strobe
   task automatic capture(logic [3:0] v, logic s);
      logic [3:0] c;
      int n;
      c = ~v;
      n = 0;
      while (fb_count === v && n < 40) begin
         tick();
         n++;
      end
      while (fb_count !== v && n < 300) begin
         tick();
         n++;
      end
      tick(3);
      fin = s;
      ext_strobe = s;
      while (code_valid !== 1'b1 && n < 320) begin
         tick();
         n++;
      end
      if (n >= 300) begin
         errors++;
         $display("mismatch capture expected %h seen timeout", c);
         fin = 1'b1;
         ext_strobe = 1'b0;
         tick(4);
         return;
      end
      compare("phase_code", c, phase_code);
      compare("phase_error", 4'h7 - c, phase_error);
      if (!s) begin
         compare("fsk_bit", {3'h0, c[3]}, {3'h0, fsk_bit});
      end
      tick();
      compare("code_valid", 4'h0, {3'h0, code_valid});
      fin = 1'b1;
      ext_strobe = 1'b0;
      tick(4);
   endtask
   task automatic t_codes;
      for (int i = 0; i < 16; i++) begin
         capture(i[3:0], 1'b0);
      end
      compare("lock_valid", 4'h0, {3'h0, lock_valid});
      compare("fin_div", 4'h1, {3'h0, fin_div});
      $display("test codes done");
   endtask
   task automatic t_lock;
      int n;
      edge_mode = 1'b0;
      capture(4'h2, 1'b0);
      capture(4'h9, 1'b0);
      compare("lock_valid", 4'h1, {3'h0, lock_valid});
      compare("locked", 4'h0, {3'h0, locked});
      // Timer was reloaded four cycles before capture returned
      n = 0;
      while (locked !== 1'b1 && n < TIMEOUT_CYC + 20) begin
         tick();
         n++;
      end
      compare_cycles("lock_delay", TIMEOUT_CYC - 4, n);
      capture(4'h2, 1'b0);
      compare("locked", 4'h1, {3'h0, locked});
      capture(4'hb, 1'b0);
      compare("locked", 4'h0, {3'h0, locked});
      $display("test lock done");
   endtask
   task automatic t_strobe;
      strobe_mode = 1'b1;
      capture(4'h5, 1'b1);
      capture(4'hc, 1'b1);
      strobe_mode = 1'b0;
      $display("test strobe done");
   endtask
   initial begin
      tick(3);
      reset_n = 1'b1;
      tick();
      compare("phase_code", 4'hf, phase_code);
      compare("locked", 4'h0, {3'h0, locked});
      t_codes();
      t_lock();
      t_strobe();
      end_of_test();
   end
endmodule
